// ==== seq_pkg.sv ====
// constants for the power, wake and fast clock sequencer
// assumes one 250 MHz clock; 32 kHz tick input arrives synchronous to it
package seq_pkg;
    // core clock rate
    localparam int MCLK_MHZ = 250;
    // slow oscillator rate, in hertz
    localparam int OSC_HZ = 32768;

    // supply monitor timeout, in microseconds, and in slow ticks
    localparam int MON_TIMEOUT_US = 1500000;
    localparam logic [15:0] MON_TIMEOUT_TICKS =
        16'((64'(MON_TIMEOUT_US) * OSC_HZ + 500000) / 1000000);

    // least wake pulse width, in ns; least time rounds up
    localparam int WAKE_MIN_NS = 1000;
    localparam logic [7:0] WAKE_MIN_CYC = 8'((WAKE_MIN_NS * MCLK_MHZ + 999) / 1000);

    // wake to power hold delay, in ns (typical)
    localparam int HOLD_DLY_NS = 1000;
    localparam logic [7:0] HOLD_DLY_CYC = 8'((HOLD_DLY_NS * MCLK_MHZ) / 1000);

    // fast clock enable to clock-ready delay, in microseconds, and in slow ticks
    localparam int READY_DLY_US = 7820;
    localparam logic [8:0] READY_DLY_TICKS =
        9'((READY_DLY_US * OSC_HZ / 1000 + 500) / 1000);

    // shutdown to clock off delay, in microseconds, and in slow ticks
    localparam int CLK_OFF_DLY_US = 1950;
    localparam logic [6:0] CLK_OFF_DLY_TICKS =
        7'((CLK_OFF_DLY_US * OSC_HZ / 1000 + 500) / 1000);

    // shutdown to power drop delay, in microseconds, and in slow ticks
    localparam int PWR_OFF_DLY_US = 2930;
    localparam logic [6:0] PWR_OFF_DLY_TICKS =
        7'((PWR_OFF_DLY_US * OSC_HZ / 1000 + 500) / 1000);

    // power sequencing states
    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_WAKE_WAIT,
        PWR_ON,
        PWR_SHUTTING
    } pwr_state_e;
endpackage

// ==== power_wake_clock_sequencer.sv ====
// power, wake and fast clock sequencer: reset release, wake detection,
// power hold, fast clock start/stop and clock-ready indication
// assumes all inputs synchronous to MCLK_I; OSC32K_I is the 32 kHz level
//
// Function
// (R1) reset output held low about 1.5 s after supply rises, then released
// (R2) host holds wake high at least 1 us for a valid wake
// (R3) power hold output goes high about 1 us after valid wake
// (R4) with locked loop enabled, clock and loop run within 10 ms
// (R5) with locked loop disabled, fast clock starts within 10 us
// (R6) clock start gated by AND of external reset, monitor, power hold
// (R7) turn-on timed from later of low-supply-ok or external reset rising
// (R8) fast clock always starts from logic low
// (R9) clock ready goes low 7.82 ms after fast clock enabled, loop on
// (R10) clock ready serves as interrupt telling host clock has started
// (R11) loop disabled: no clock ready, interrupt stays deasserted
// (R12) fast clock kept running 1.95 ms after shutdown command
// (R13) power hold drops 2.93 ms after shutdown command, after clock stops
// (R14) reset output active low, open drain, low while supply below threshold
// (R15) millisecond delays counted in 32.768 kHz oscillator cycles
// (R16) wake detector synchronous, rejects pulses shorter than minimum width
`timescale 1ns/10ps
module power_wake_clock_sequencer #(
    parameter logic [15:0] MON_TIMEOUT = seq_pkg::MON_TIMEOUT_TICKS
) (
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic OSC32K_I,
    input wire logic SUPPLY_OK_I,
    input wire logic LOW_SUPPLY_OK_I,
    input wire logic WAKE_EVENT_I,
    input wire logic SHUTDOWN_CMD_I,
    input wire logic LOCKED_LOOP_ENABLE_I,
    input wire logic RESET_PIN_I,
    output logic RESET_PIN_O,
    output logic RESET_PIN_OE_O,
    output logic POWER_HOLD_OUT_O,
    output logic FAST_CLOCK_OUT_O,
    output logic CLOCK_READY_N_O
);
    // slow tick edge detect
    logic osc_q;
    logic tick;

    // supply monitor state
    logic [15:0] mon_cnt;
    logic [15:0] next_mon_cnt;
    logic released;
    logic next_released;

    // wake detector state
    logic [7:0] wake_cnt;
    logic [7:0] next_wake_cnt;
    logic wake_valid;
    logic next_wake_valid;

    // power sequencing state
    seq_pkg::pwr_state_e state;
    seq_pkg::pwr_state_e next_state;
    logic [7:0] dly_cnt;
    logic [7:0] next_dly_cnt;
    logic [6:0] shut_cnt;
    logic [6:0] next_shut_cnt;
    logic clk_kill;
    logic next_clk_kill;
    logic hold;
    logic next_hold;

    // fast clock state
    logic clk_on;
    logic next_clk_on;
    logic fclk;
    logic next_fclk;
    logic [8:0] rdy_cnt;
    logic [8:0] next_rdy_cnt;
    logic rdy_n;
    logic next_rdy_n;
    logic start_cond;

    // slow tick: a rising oscillator edge seen between two core clocks
    assign tick = OSC32K_I & ~osc_q; // (R15)

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= OSC32K_I;
        end
    end

    // supply monitor: restart the timeout whenever the supply dips
    always_comb begin
        next_mon_cnt = mon_cnt;
        next_released = released;
        if (!SUPPLY_OK_I) begin
            next_mon_cnt = 16'h0000; // (R14)
            next_released = 1'b0; // (R14)
        end else if (!released && tick) begin
            if (mon_cnt >= MON_TIMEOUT - 16'h0001) begin
                next_released = 1'b1; // (R1)
            end else begin
                next_mon_cnt = mon_cnt + 16'h0001; // (R1)
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            mon_cnt <= 16'h0000;
            released <= 1'b0;
            RESET_PIN_O <= 1'b0; // (R14)
            RESET_PIN_OE_O <= 1'b1;
        end else begin
            mon_cnt <= next_mon_cnt;
            released <= next_released;
            // open drain: the data flop stays low, only the enable moves
            RESET_PIN_O <= 1'b0; // (R14)
            RESET_PIN_OE_O <= ~next_released;
        end
    end

    // wake width filter: one valid pulse per wake, none for short glitches
    always_comb begin
        next_wake_cnt = wake_cnt;
        next_wake_valid = 1'b0;
        if (!WAKE_EVENT_I) begin
            next_wake_cnt = 8'h00; // (R16)
        end else if (wake_cnt < wake_limit()) begin
            next_wake_cnt = wake_cnt + 8'h01; // (R16)
        end else if (wake_cnt == wake_limit()) begin
            next_wake_cnt = wake_cnt + 8'h01; // saturate past threshold
            next_wake_valid = 1'b1; // (R16)
        end
    end

    function automatic logic [7:0] wake_limit();
        return seq_pkg::WAKE_MIN_CYC - 8'h01;
    endfunction

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            wake_cnt <= 8'h00;
            wake_valid <= 1'b0;
        end else begin
            wake_cnt <= next_wake_cnt;
            wake_valid <= next_wake_valid;
        end
    end

    // power sequencing; on shutdown the clock stops before power drops so cleanup can finish
    always_comb begin
        next_state = state;
        next_dly_cnt = dly_cnt;
        next_shut_cnt = shut_cnt;
        next_clk_kill = clk_kill;
        next_hold = hold;
        unique case (state)
            seq_pkg::PWR_OFF: begin
                next_hold = 1'b0;
                next_clk_kill = 1'b0;
                next_dly_cnt = 8'h00;
                if (wake_valid && released) begin
                    next_state = seq_pkg::PWR_WAKE_WAIT;
                end
            end
            seq_pkg::PWR_WAKE_WAIT: begin
                if (dly_cnt >= seq_pkg::HOLD_DLY_CYC - 8'h02) begin
                    next_hold = 1'b1; // (R3)
                    next_state = seq_pkg::PWR_ON;
                end else begin
                    next_dly_cnt = dly_cnt + 8'h01; // (R3)
                end
            end
            seq_pkg::PWR_ON: begin
                next_shut_cnt = 7'h00;
                if (SHUTDOWN_CMD_I) begin
                    next_state = seq_pkg::PWR_SHUTTING;
                end
            end
            seq_pkg::PWR_SHUTTING: begin
                if (tick) begin
                    next_shut_cnt = shut_cnt + 7'h01; // (R15)
                    if (shut_cnt == seq_pkg::CLK_OFF_DLY_TICKS - 7'h01) begin
                        next_clk_kill = 1'b1; // (R12)
                    end
                    if (shut_cnt == seq_pkg::PWR_OFF_DLY_TICKS - 7'h01) begin
                        next_hold = 1'b0; // (R13)
                        next_state = seq_pkg::PWR_OFF;
                    end
                end
            end
        endcase
        // losing the supply drops power at once
        if (!released) begin
            next_state = seq_pkg::PWR_OFF;
            next_hold = 1'b0;
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state <= seq_pkg::PWR_OFF;
            dly_cnt <= 8'h00;
            shut_cnt <= 7'h00;
            clk_kill <= 1'b0;
            hold <= 1'b0;
            POWER_HOLD_OUT_O <= 1'b0;
        end else begin
            state <= next_state;
            dly_cnt <= next_dly_cnt;
            shut_cnt <= next_shut_cnt;
            clk_kill <= next_clk_kill;
            hold <= next_hold;
            POWER_HOLD_OUT_O <= next_hold;
        end
    end

    // clock gate: starts as soon as the last of its conditions rises
    assign start_cond = RESET_PIN_I & released & hold & LOW_SUPPLY_OK_I; // (R6) (R7)

    // fast clock and lock indication
    always_comb begin
        next_clk_on = start_cond & ~clk_kill; // (R5) (R12)
        next_rdy_cnt = rdy_cnt;
        next_rdy_n = rdy_n;
        // parks low so every restart begins on a low phase
        next_fclk = clk_on ? ~fclk : 1'b0; // (R8)
        if (!clk_on || !LOCKED_LOOP_ENABLE_I) begin
            next_rdy_cnt = 9'h000;
            next_rdy_n = 1'b1; // (R11)
        end else if (rdy_n && tick) begin
            if (rdy_cnt == seq_pkg::READY_DLY_TICKS - 9'h001) begin
                next_rdy_n = 1'b0; // (R9) (R10) (R4)
            end else begin
                next_rdy_cnt = rdy_cnt + 9'h001; // (R9)
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            clk_on <= 1'b0;
            fclk <= 1'b0;
            rdy_cnt <= 9'h000;
            rdy_n <= 1'b1;
            FAST_CLOCK_OUT_O <= 1'b0;
            CLOCK_READY_N_O <= 1'b1;
        end else begin
            clk_on <= next_clk_on;
            fclk <= next_fclk;
            rdy_cnt <= next_rdy_cnt;
            rdy_n <= next_rdy_n;
            FAST_CLOCK_OUT_O <= next_fclk;
            CLOCK_READY_N_O <= next_rdy_n;
        end
    end
endmodule

// ==== host_model.sv ====
// far side: stand-in oscillator and the pulled-up reset wire
// assumes the bench clock; one tick every 8 clocks to keep runs short
`timescale 1ns/10ps
module host_model (
    input wire logic clk_i,
    input wire logic pull_low_i,
    input wire logic oe_i,
    input wire logic data_i,
    output logic osc_o,
    output logic wire_o
);
    logic [1:0] div = 2'h0;
    logic osc = 1'b0;
    // oscillator runs free, changes just after the falling edge
    always @(negedge clk_i) begin
        div <= div + 2'h1;
        if (div == 2'h3) osc <= ~osc;
    end
    assign osc_o = osc;
    // open drain with pull-up: any party pulling wins
    assign wire_o = !((oe_i && !data_i) || pull_low_i);
endmodule

// ==== power_wake_clock_sequencer_assertions.sv ====
// timing checks on the sequencer's own outputs
// assumes one clock domain and the async active-low reset
`timescale 1ns/10ps
module seq_checker #(
    parameter logic [15:0] MON_TIMEOUT = seq_pkg::MON_TIMEOUT_TICKS
) (
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic SUPPLY_OK_I,
    input wire logic LOW_SUPPLY_OK_I,
    input wire logic WAKE_EVENT_I,
    input wire logic LOCKED_LOOP_ENABLE_I,
    input wire logic RESET_PIN_I,
    input wire logic RESET_PIN_OE_O,
    input wire logic POWER_HOLD_OUT_O,
    input wire logic FAST_CLOCK_OUT_O,
    input wire logic CLOCK_READY_N_O
);
    logic [8:0] wake_run;
    logic [8:0] next_wake_run;
    // consecutive wake samples, saturating so a long press fires once
    always_comb begin
        next_wake_run = WAKE_EVENT_I ? wake_run + {8'h00, wake_run != 9'h1ff} : 9'h000;
    end
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) wake_run <= 9'h000;
        else wake_run <= next_wake_run;
    end
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);
    a_wake_to_hold: assert property (
        wake_run == 9'h0fa && !POWER_HOLD_OUT_O && !RESET_PIN_OE_O && SUPPLY_OK_I
        |-> ##[240:258] $rose(POWER_HOLD_OUT_O)) else $error("hold late after wake");
    a_reset_when_low: assert property (
        !SUPPLY_OK_I |=> RESET_PIN_OE_O) else $error("reset wire free, supply low");
    a_clock_half_rate: assert property (
        FAST_CLOCK_OUT_O |=> !FAST_CLOCK_OUT_O) else $error("fast clock high twice");
    a_gate_low_supply: assert property (
        $past(!LOW_SUPPLY_OK_I, 2) && $past(!LOW_SUPPLY_OK_I) |-> !FAST_CLOCK_OUT_O)
        else $error("clock runs without low supply ok");
    a_gate_ext_reset: assert property (
        $past(!RESET_PIN_I, 2) && $past(!RESET_PIN_I) |-> !FAST_CLOCK_OUT_O)
        else $error("clock runs with reset wire low");
    a_ready_needs_loop: assert property (
        !LOCKED_LOOP_ENABLE_I && $past(!LOCKED_LOOP_ENABLE_I) |-> CLOCK_READY_N_O)
        else $error("ready low with loop off");
    a_ready_fall_cause: assert property (
        $fell(CLOCK_READY_N_O) |-> POWER_HOLD_OUT_O && LOCKED_LOOP_ENABLE_I)
        else $error("ready fell without loop or hold");
    a_clock_before_drop: assert property (
        $fell(POWER_HOLD_OUT_O) && SUPPLY_OK_I |-> !$past(FAST_CLOCK_OUT_O)
        && !$past(FAST_CLOCK_OUT_O, 2)) else $error("hold dropped with clock live");
    c_hold: cover property ($rose(POWER_HOLD_OUT_O));
    c_ready: cover property ($fell(CLOCK_READY_N_O));
    c_release: cover property ($fell(RESET_PIN_OE_O));
endmodule
bind power_wake_clock_sequencer seq_checker #(.MON_TIMEOUT(MON_TIMEOUT)) u_chk (
    .MCLK_I(MCLK_I), .NRST_I(NRST_I), .SUPPLY_OK_I(SUPPLY_OK_I),
    .LOW_SUPPLY_OK_I(LOW_SUPPLY_OK_I), .WAKE_EVENT_I(WAKE_EVENT_I),
    .LOCKED_LOOP_ENABLE_I(LOCKED_LOOP_ENABLE_I), .RESET_PIN_I(RESET_PIN_I),
    .RESET_PIN_OE_O(RESET_PIN_OE_O), .POWER_HOLD_OUT_O(POWER_HOLD_OUT_O),
    .FAST_CLOCK_OUT_O(FAST_CLOCK_OUT_O), .CLOCK_READY_N_O(CLOCK_READY_N_O));

// ==== power_wake_clock_sequencer_tb_top.sv ====
// self-checking bench: monitor, wake, clock gating, shutdown, ready
// assumes a 4 ns clock, monitor timeout shortened to 4 ticks
`timescale 1ns/10ps
module power_wake_clock_sequencer_tb_top;
    logic clk, nrst, sup, lsup, wake, shut, lle, pull, osc, rw, rd, oe, hold, fclk, rdy_n;
    int bad_count = 0;
    int check_count = 0;
    int n;
    power_wake_clock_sequencer #(.MON_TIMEOUT(16'h0004)) u_dut (.MCLK_I(clk), .NRST_I(nrst),
        .OSC32K_I(osc), .SUPPLY_OK_I(sup), .LOW_SUPPLY_OK_I(lsup), .WAKE_EVENT_I(wake),
        .SHUTDOWN_CMD_I(shut), .LOCKED_LOOP_ENABLE_I(lle), .RESET_PIN_I(rw),
        .RESET_PIN_O(rd), .RESET_PIN_OE_O(oe), .POWER_HOLD_OUT_O(hold),
        .FAST_CLOCK_OUT_O(fclk), .CLOCK_READY_N_O(rdy_n));
    host_model u_host (.clk_i(clk), .pull_low_i(pull), .oe_i(oe), .data_i(rd), .osc_o(osc),
        .wire_o(rw));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", s, e, g);
        end
    endtask
    task automatic chk_rng(input string s, input int lo, input int hi);
        check_count++;
        if (n < lo || n > hi) begin
            bad_count++;
            $display("ERROR %s expected %0d..%0d seen %0d", s, lo, hi, n);
        end
    endtask
    // bounded wait; a timeout ends the run as a mismatch
    task automatic wait_lvl(input int sel, input logic v, input int lim);
        for (n = 1; n <= lim; n++) begin
            @(negedge clk);
            if ((sel == 0 ? oe : sel == 1 ? hold : sel == 2 ? fclk : rdy_n) === v) return;
        end
        bad_count++;
        $display("ERROR wait %0d expected %b seen timeout", sel, v);
        print_verdict();
    endtask
    task automatic t_wake(input logic loop, input int len, input logic ok);
        lle = loop;
        wake = 1'b1;
        repeat (len) @(negedge clk);
        wake = 1'b0;
        if (!ok) begin
            repeat (600) @(negedge clk);
            chk("hold after short pulse", 1'b0, hold);
            return;
        end
        wait_lvl(1, 1'b1, 300);
        chk_rng("wake to hold", 245, 258);
        chk("clock starts low", 1'b0, fclk);
        wait_lvl(2, 1'b1, 2500);
        chk_rng("clock start", 2, 4);
        if (loop) begin
            wait_lvl(3, 1'b0, 2200);
            chk_rng("clock ready", 2035, 2060);
        end else begin
            repeat (2200) @(negedge clk);
            chk("ready with loop off", 1'b1, rdy_n);
        end
    endtask
    task automatic t_gate();
        for (int i = 0; i < 2; i++) begin
            lsup = i[0];
            pull = i[0]; // one gate input dropped per pass
            repeat (3) @(negedge clk);
            chk("gated clock", 1'b0, fclk | u_dut.FAST_CLOCK_OUT_O);
            lsup = 1'b1;
            pull = 1'b0;
            wait_lvl(2, 1'b1, 10);
            chk_rng("clock restart", 2, 4);
        end
    endtask
    task automatic t_shutdown();
        logic p;
        shut = 1'b1;
        repeat (496) @(negedge clk);
        p = fclk;
        @(negedge clk);
        chk("clock kept alive", 1'b1, p ^ fclk);
        repeat (64) @(negedge clk);
        p = fclk;
        @(negedge clk);
        chk("clock parked", 1'b0, fclk | p);
        chk("hold kept", 1'b1, hold);
        wait_lvl(1, 1'b0, 400);
        chk_rng("hold drop", 195, 222);
        shut = 1'b0;
    endtask
    initial begin
        {nrst, sup, wake, shut, lle, pull} = 6'h00;
        lsup = 1'b1;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        chk("reset held", 1'b1, oe);
        chk("reset wire data", 1'b0, rd);
        sup = 1'b1;
        wait_lvl(0, 1'b0, 100);
        chk_rng("monitor timeout", 24, 40);
        t_wake(1'b0, 200, 1'b0);
        t_wake(1'b0, 250, 1'b1);
        t_gate();
        t_shutdown();
        t_wake(1'b1, 250, 1'b1);
        sup = 1'b0;
        repeat (2) @(negedge clk);
        chk("reset wire on loss", 1'b0, rw);
        chk("hold on loss", 1'b0, hold);
        print_verdict();
    end
    initial begin
        #200000;
        bad_count++;
        $display("ERROR run limit expected finish seen timeout");
        print_verdict();
    end
endmodule
